// ---- rtl/oac_map.vh ----
// Register offsets, field positions, reset values and timing for the
// amplifier control block. Included by the sequencer and top files; the synchroniser does not use it.
`ifndef OAC_MAP_VH
`define OAC_MAP_VH
`define OAC_ADDR_CSR 12'h000
`define OAC_ADDR_STAT 12'h004
`define OAC_ADDR_ROUTE 12'h008
`define OAC_ADDR_OFFS 12'h00c
`define OAC_BIT_DONE 7
`define OAC_BIT_REQ 6
`define OAC_BIT_AVG 5
`define OAC_BIT_PWR 4
`define OAC_BIT_GAIN 3
`define OAC_CSR_WMASK 8'h78
`define OAC_CSR_RST 8'h00
`define OAC_ROUTE_RST 8'h00
`define OAC_BIT_RT_ADC 0
`define OAC_BIT_RT_MTC 1
`define OAC_AVG_PASSES 5'h10
`define OAC_PASS_CYCLES 16'h0040
`define OAC_STAB_NS 10000
`define OAC_CLK_NS 10
`define OAC_STAB_CYCLES ((`OAC_STAB_NS + `OAC_CLK_NS - 1) / `OAC_CLK_NS)
`endif

// ---- rtl/oac_sync.v ----
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes the input is asynchronous to i_ref_clk.
`timescale 1ns/100ps
module oac_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Level in and filtered level out
  input wire i_async,
  output reg o_level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      o_level <= RST_VAL;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Accept a change only once stages two and three agree
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule

// ---- rtl/oac_cal_seq.v ----
// Offset compensation sequencer: one pass or an averaged run of passes.
// Assumes the analog trim code arrives on i_sample, valid at pass end.
`timescale 1ns/100ps
`include "oac_map.vh"
module oac_cal_seq #(
  parameter PASS_CYCLES = `OAC_PASS_CYCLES,
  parameter TRIM_W = 6
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Control
  input wire i_start,
  input wire i_abort,
  input wire i_avg,
  input wire [TRIM_W-1:0] i_sample,
  // Result
  output reg o_done,
  output reg [TRIM_W-1:0] o_trim
);
  localparam S_IDLE = 3'b001;
  localparam S_RUN = 3'b010;
  localparam S_DONE = 3'b100;
  reg [2:0] st_q;
  reg [15:0] cyc_q;
  reg [4:0] pass_q;
  reg [TRIM_W+3:0] acc_q;
  wire [4:0] passes = i_avg ? `OAC_AVG_PASSES : 5'h01;
  wire [TRIM_W+3:0] acc_nx = acc_q + {4'h0, i_sample};
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= S_IDLE;
      cyc_q <= 16'h0000;
      pass_q <= 5'h00;
      acc_q <= {(TRIM_W+4){1'b0}};
      o_done <= 1'b0;
      o_trim <= {TRIM_W{1'b0}};
    end else if (i_abort) begin
      // Clearing the request drops the stored correction
      st_q <= S_IDLE;
      o_done <= 1'b0;
      o_trim <= {TRIM_W{1'b0}};
      cyc_q <= 16'h0000;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (i_start) begin
            st_q <= S_RUN;
            cyc_q <= 16'h0000;
            pass_q <= 5'h00;
            acc_q <= {(TRIM_W+4){1'b0}};
          end
        end
        S_RUN: begin
          if (cyc_q == PASS_CYCLES[15:0] - 16'h0001) begin
            cyc_q <= 16'h0000;
            acc_q <= acc_nx;
            pass_q <= pass_q + 5'h01;
            if (pass_q + 5'h01 == passes) begin
              st_q <= S_DONE;
              o_done <= 1'b1;
              o_trim <= i_avg ? acc_nx[TRIM_W+3:4] : i_sample;
            end
          end else begin
            cyc_q <= cyc_q + 16'h0001;
          end
        end
        S_DONE: st_q <= S_DONE;
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/oac_top.v ----
// Amplifier control block: APB registers, power and pin switches, halt
// handling, internal routing and the offset compensation sequencer.
// Assumes an APB master on i_ref_clk; pins arrive asynchronously.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "oac_map.vh"
module oac_top #(
  parameter PASS_CYCLES = `OAC_PASS_CYCLES,
  parameter STAB_CYCLES = `OAC_STAB_CYCLES,
  parameter TRIM_W = 6
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // Low power modes
  input wire i_wait_mode,
  input wire i_halt_mode,
  // Analog side
  input wire [TRIM_W-1:0] i_trim_sample,
  input wire [2:0] i_pin_level,
  output reg o_amp_enable,
  output reg o_pin_switch_close,
  output reg o_out_pin_oe,
  output reg o_route_adc,
  output reg o_route_motor_control_cell,
  output reg o_gain_range_select,
  output reg [TRIM_W-1:0] o_offset_trim,
  output reg o_amp_ready
);
  reg [7:0] csr_q;
  localparam A_IDLE = 2'b01;
  localparam A_ANSWER = 2'b10;
  reg [7:0] route_q;
  reg [1:0] apb_st_q;
  reg [15:0] stab_q;
  reg req_prev_q;
  wire halt_s;
  wire [2:0] pin_s;
  wire cal_done;
  wire [TRIM_W-1:0] cal_trim;

  wire wr = i_psel & i_penable & i_pwrite;
  wire req = csr_q[`OAC_BIT_REQ];
  wire pwr = csr_q[`OAC_BIT_PWR];
  // Amplifier live only when powered and not halted; wait is ignored
  wire amp_live = pwr & ~halt_s;

  // One-hot decode of the four register words, shared by write and read
  function [3:0] reg_hit;
    input [11:0] addr;
    begin
      case (addr)
        `OAC_ADDR_CSR: reg_hit = 4'h1;
        `OAC_ADDR_STAT: reg_hit = 4'h2;
        `OAC_ADDR_ROUTE: reg_hit = 4'h4;
        `OAC_ADDR_OFFS: reg_hit = 4'h8;
        default: reg_hit = 4'h0;
      endcase
    end
  endfunction

  // An eight-bit register placed in the low byte of a bus word
  function [31:0] byte_word;
    input [7:0] val;
    begin
      byte_word = {24'h000000, val};
    end
  endfunction

  oac_sync u_halt_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(i_halt_mode),
    .o_level(halt_s)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      oac_sync u_pin_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async(i_pin_level[g]),
        .o_level(pin_s[g])
      );
    end
  endgenerate

  oac_cal_seq #(
    .PASS_CYCLES(PASS_CYCLES),
    .TRIM_W(TRIM_W)
  ) u_cal (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(req & ~req_prev_q & amp_live),
    .i_abort(~req),
    .i_avg(csr_q[`OAC_BIT_AVG]),
    .i_sample(i_trim_sample),
    .o_done(cal_done),
    .o_trim(cal_trim)
  );

  // Control registers
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      csr_q <= `OAC_CSR_RST;
      route_q <= `OAC_ROUTE_RST;
      req_prev_q <= 1'b0;
    end else begin
      req_prev_q <= req;
      if (wr & o_pready) begin
        if (reg_hit(i_paddr) == 4'h1) begin
          // Done bit and reserved bits are not writable
          csr_q <= i_pwdata[7:0] & `OAC_CSR_WMASK;
        end
        if (reg_hit(i_paddr) == 4'h4) begin
          route_q <= {6'h00, i_pwdata[1:0]};
        end
      end
    end
  end

  // Halt wake-up stabilisation counter
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stab_q <= 16'h0000;
      o_amp_ready <= 1'b0;
    end else begin
      if (!amp_live) begin
        stab_q <= 16'h0000;
        o_amp_ready <= 1'b0;
      end else if (stab_q == STAB_CYCLES[15:0]) begin
        o_amp_ready <= 1'b1;
      end else begin
        stab_q <= stab_q + 16'h0001;
        o_amp_ready <= 1'b0;
      end
    end
  end

  // Analog controls, all registered
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_amp_enable <= 1'b0;
      o_pin_switch_close <= 1'b0;
      o_out_pin_oe <= 1'b0;
      o_route_adc <= 1'b0;
      o_route_motor_control_cell <= 1'b0;
      o_gain_range_select <= 1'b0;
      o_offset_trim <= {TRIM_W{1'b0}};
    end else begin
      o_amp_enable <= amp_live;
      o_pin_switch_close <= amp_live;
      o_out_pin_oe <= amp_live;
      // Pin stays open to ADC and motor cell even when unpowered
      o_route_adc <= route_q[`OAC_BIT_RT_ADC];
      o_route_motor_control_cell <= route_q[`OAC_BIT_RT_MTC];
      o_gain_range_select <= csr_q[`OAC_BIT_GAIN];
      o_offset_trim <= cal_trim;
    end
  end

  // APB slave: one wait state, errors on unmapped addresses
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      apb_st_q <= A_IDLE;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      case (apb_st_q)
        A_IDLE: begin
          if (i_psel & i_penable) begin
            apb_st_q <= A_ANSWER;
            o_pready <= 1'b1;
            case (reg_hit(i_paddr))
              4'h1: begin
                // Done reads as set only while the request stands
                o_prdata <= byte_word({cal_done & req, csr_q[6:0]});
              end
              4'h2: begin
                // Pin levels read back whatever their analog use
                o_prdata <= byte_word({4'h0, o_amp_ready, pin_s});
              end
              4'h4: begin
                o_prdata <= byte_word(route_q);
              end
              4'h8: begin
                o_prdata <= {{(32-TRIM_W){1'b0}}, cal_trim};
              end
              default: begin
                o_pslverr <= 1'b1;
              end
            endcase
          end
        end
        A_ANSWER: begin
          apb_st_q <= A_IDLE;
        end
        default: begin
          apb_st_q <= A_IDLE;
        end
      endcase
    end
  end
  // No interrupt output exists; completion is polled in the CSR
endmodule

// ---- verification/oac_top_sva.sv ----
// Checker for the amplifier control block, bound to its top module.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
module oac_top_chk #(
  parameter TRIM_W = 6
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Register bus
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  // Amplifier side
  input wire i_halt_mode,
  input wire o_amp_enable,
  input wire o_pin_switch_close,
  input wire o_out_pin_oe,
  input wire o_route_adc,
  input wire o_route_motor_control_cell,
  input wire [TRIM_W-1:0] o_offset_trim,
  input wire o_amp_ready
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("bus answer missing");
  a_err_unmapped: assert property (o_pready && i_paddr[11:4] != 8'h00
    |-> o_pslverr) else $error("unmapped access not refused");
  a_data_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  a_switch_track: assert property (o_pin_switch_close == o_amp_enable &&
    o_out_pin_oe == o_amp_enable) else $error("pin switches off power");
  a_halt_off: assert property (i_halt_mode [*8] |-> !o_amp_enable)
    else $error("amplifier on in halt");
  a_ready_off: assert property (!o_amp_enable ##1 !o_amp_enable
    |-> !o_amp_ready) else $error("ready while off");
  a_trim_clear: assert property (o_pready && i_pwrite &&
    i_paddr == 12'h000 && !i_pwdata[6] |-> ##3 o_offset_trim == 0)
    else $error("trim kept after request cleared");
  a_route_set: assert property (o_pready && i_pwrite &&
    i_paddr == 12'h008 |-> ##2 o_route_adc == $past(i_pwdata[0], 2) &&
    o_route_motor_control_cell == $past(i_pwdata[1], 2))
    else $error("routing not updated");
endmodule
bind oac_top oac_top_chk #(.TRIM_W(TRIM_W)) i_chk (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_halt_mode(i_halt_mode), .o_amp_enable(o_amp_enable),
  .o_pin_switch_close(o_pin_switch_close), .o_out_pin_oe(o_out_pin_oe),
  .o_route_adc(o_route_adc),
  .o_route_motor_control_cell(o_route_motor_control_cell),
  .o_offset_trim(o_offset_trim), .o_amp_ready(o_amp_ready));

// ---- verification/oac_top_test.sv ----
// Self-checking bench for the amplifier control block over APB.
// Assumes short pass and stabilisation counts set below.
`timescale 1ns/100ps
module oac_top_test;
  localparam int PC = 4;
  localparam int SC = 8;
  logic clk, rst, psel, pen, pwr, wmode, hmode, pready, pslverr, err;
  logic [11:0] paddr, ta;
  logic [31:0] pwdata, prdata, rd, td, te;
  logic [5:0] samp, trim;
  logic [2:0] pins;
  logic amp_en, sw, oe, r_adc, r_mcc, gain, amp_rdy, tx, alt;
  int n_errors, total_checks, cyc, t0, dt;
  logic [76:0] rows [6] = '{{12'h000, 32'h8f, 32'h08, 1'b0},
    {12'h000, 32'h1f, 32'h18, 1'b0}, {12'h008, 32'hff, 32'h03, 1'b0},
    {12'h008, 32'h02, 32'h02, 1'b0}, {12'h00c, 32'h3f, 32'h00, 1'b0},
    {12'h010, 32'h01, 32'h00, 1'b1}};
  oac_top #(.PASS_CYCLES(PC), .STAB_CYCLES(SC), .TRIM_W(6)) i_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_wait_mode(wmode),
    .i_halt_mode(hmode), .i_trim_sample(samp), .i_pin_level(pins),
    .o_amp_enable(amp_en), .o_pin_switch_close(sw), .o_out_pin_oe(oe),
    .o_route_adc(r_adc), .o_route_motor_control_cell(r_mcc),
    .o_gain_range_select(gain), .o_offset_trim(trim), .o_amp_ready(amp_rdy));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    total_checks++;
    if (seen !== ex) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task poll;
    t0 = cyc;
    do begin
      apb(0, 12'h000, 0);
    end while (rd[7] !== 1'b1);
    dt = cyc - t0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Alternate the trim sample once per pass so averaging shows
    if (alt && cyc % PC == 0)
      samp <= samp ^ 6'h10;
    if (cyc == 20000) begin
      n_errors++;
      results;
    end
  end
  initial begin
    rst = 1;
    {psel, pen, pwr, wmode, hmode, alt} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    samp = 6'h00;
    pins = 3'h5;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, 12'h000, 0);
    chk("csr reset", rd, 32'h0);
    apb(0, 12'h004, 0);
    chk("pin levels", rd, 32'h5);
    chk("oe reset", oe, 0);
    foreach (rows[i]) begin
      {ta, td, te, tx} = rows[i];
      apb(1, ta, td);
      chk("write err", err, tx);
      apb(0, ta, 0);
      chk("readback", rd, te);
      chk("read err", err, tx);
    end
    chk("route", {r_mcc, r_adc}, 2'h2);
    chk("gain", gain, 1);
    chk("switch", {sw, oe, amp_en}, 3'h7);
    repeat (SC + 4) @(posedge clk);
    apb(0, 12'h004, 0);
    chk("stable", rd, 32'h0d);
    samp <= 6'h15;
    apb(1, 12'h000, 32'h58);
    poll;
    chk("single fast", dt < 16 * PC, 1);
    chk("single trim", trim, 6'h15);
    apb(1, 12'h000, 32'h58);
    apb(0, 12'h00c, 0);
    chk("trim kept", rd, 32'h15);
    apb(1, 12'h000, 32'h18);
    apb(0, 12'h000, 0);
    chk("cleared", rd, 32'h18);
    chk("trim cleared", trim, 6'h00);
    samp <= 6'h2a;
    alt <= 1;
    apb(1, 12'h000, 32'h78);
    poll;
    alt <= 0;
    chk("avg slow", dt >= 16 * PC, 1);
    chk("avg trim", trim, 6'h32);
    wmode <= 1;
    repeat (10) @(posedge clk);
    chk("wait", {amp_en, trim}, {1'b1, 6'h32});
    hmode <= 1;
    repeat (10) @(posedge clk);
    chk("halt", {amp_en, oe, amp_rdy}, 3'h0);
    hmode <= 0;
    repeat (8) @(posedge clk);
    chk("wake", {amp_en, amp_rdy}, 2'h2);
    repeat (12) @(posedge clk);
    chk("restab", amp_rdy, 1);
    apb(1, 12'h000, 32'h0);
    repeat (3) @(posedge clk);
    chk("off", {amp_en, sw, oe, trim}, 9'h0);
    rst <= 1;
    repeat (2) @(posedge clk);
    chk("reset outs", {r_mcc, r_adc, amp_rdy, pready}, 4'h0);
    rst <= 0;
    @(posedge clk);
    apb(0, 12'h008, 0);
    chk("reset route", rd, 32'h0);
    results;
  end
endmodule
